/* File: src/gpdr_pkg.sv */
package gpdr_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    // Core clock period and shortest legal interface clock period
    localparam int CORE_PERIOD_NS = 5;
    localparam int LINK_MIN_PERIOD_NS = 15;
    // Least core cycles per interface period, rounded up
    localparam int LINK_MIN_CYCLES = (LINK_MIN_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    // Four phases are needed to centre both strobe edges in their halves
    localparam int LINK_DIV = (LINK_MIN_CYCLES > 4) ? LINK_MIN_CYCLES : 4;

    // ************************************************************
    // Phases of one interface clock period
    // ************************************************************
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_STB_FALL = 2'h1;
    localparam logic [1:0] PH_HALF_B = 2'h2;
    localparam logic [1:0] PH_LOAD = 2'h3;
    localparam logic [1:0] PH_RESET = 2'h3;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int AD_W = 32;
    localparam int BE_W = 4;
    localparam int SB_W = 8;
    localparam int AD_LANE_W = AD_W + BE_W;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic MODE_RST = 1'b0;
    localparam logic STROBE_IDLE = 1'b1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        GPDR_IDLE = 4'h1,
        GPDR_ONE_A = 4'h2,
        GPDR_ONE_B = 4'h4,
        GPDR_TWO = 4'h8
    } gpdr_lane_st_t;

    // One Qword with its byte enables, active high
    typedef struct packed {
        logic [2*BE_W-1:0] be;
        logic [2*AD_W-1:0] data;
    } gpdr_qword_t;

    // Pins of the address/data group for one half
    typedef struct packed {
        logic [BE_W-1:0] byte_en_n;
        logic [AD_W-1:0] addr_data;
    } gpdr_ad_pins_t;

endpackage

/* File: src/gpdr_clkgen.sv */
`timescale 1ns/1ps

// Divides the core clock into the shared interface clock
module gpdr_clkgen (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    output logic [1:0] phase_o,
    output logic link_clk_o
);

    logic [1:0] next_phase;
    logic next_link_clk;

    // ************************************************************
    // Phase counter
    // ************************************************************
    // High in the first two phases, so the rising edge opens a period
    always_comb begin
        next_phase = 2'(phase_o + 2'h1);
        next_link_clk = (next_phase < gpdr_pkg::PH_HALF_B);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_o <= gpdr_pkg::PH_RESET;
            link_clk_o <= 1'b0;
        end else begin
            phase_o <= next_phase;
            link_clk_o <= next_link_clk;
        end
    end

endmodule

/* File: src/gpdr_lane.sv */
`timescale 1ns/1ps

// Sends one word as two halves, either over two periods or one
module gpdr_lane #(
    parameter int W = 8,
    parameter logic [W-1:0] IDLE_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [1:0] phase_i,
    input wire logic double_rate_i,
    input wire logic valid_i,
    input wire logic [2*W-1:0] word_i,
    output logic ready_o,
    output logic [W-1:0] pins_o,
    output logic drive_o,
    output logic strobe_o
);

    gpdr_pkg::gpdr_lane_st_t state;
    gpdr_pkg::gpdr_lane_st_t next_state;
    logic [2*W-1:0] word;
    logic [2*W-1:0] next_word;
    logic [1:0] next_phase;
    logic accept;
    logic can_load;
    logic next_ready;
    logic [W-1:0] next_pins;
    logic next_drive;
    logic next_strobe;

    // ************************************************************
    // Sequencer
    // ************************************************************
    // State only moves at the end of a period
    always_comb begin
        next_phase = 2'(phase_i + 2'h1);
        accept = valid_i && ready_o;
        can_load = (state != gpdr_pkg::GPDR_ONE_A);
        next_ready = (phase_i == gpdr_pkg::PH_HALF_B) && can_load;
        next_word = accept ? word_i : word;
        next_state = state;
        if (phase_i == gpdr_pkg::PH_LOAD) begin
            if (accept) begin
                next_state = double_rate_i ? gpdr_pkg::GPDR_TWO : gpdr_pkg::GPDR_ONE_A;
            end else if (state == gpdr_pkg::GPDR_ONE_A) begin
                next_state = gpdr_pkg::GPDR_ONE_B;
            end else begin
                next_state = gpdr_pkg::GPDR_IDLE;
            end
        end
    end

    // Pin values for the coming phase, so pins move with the clock out
    always_comb begin
        next_pins = IDLE_VAL;
        next_strobe = gpdr_pkg::STROBE_IDLE;
        next_drive = 1'b1;
        unique case (next_state)
            gpdr_pkg::GPDR_IDLE: begin
                next_drive = 1'b0;
            end
            gpdr_pkg::GPDR_ONE_A: begin
                next_pins = next_word[W-1:0];
            end
            gpdr_pkg::GPDR_ONE_B: begin
                next_pins = next_word[2*W-1:W];
            end
            gpdr_pkg::GPDR_TWO: begin
                // Edges sit mid-half: fall in phase 1, rise in phase 3
                next_pins = next_phase[1] ? next_word[2*W-1:W] : next_word[W-1:0];
                next_strobe = (next_phase == gpdr_pkg::PH_FIRST) ||
                              (next_phase == gpdr_pkg::PH_LOAD);
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= gpdr_pkg::GPDR_IDLE;
            word <= '0;
            ready_o <= 1'b0;
            pins_o <= IDLE_VAL;
            drive_o <= 1'b0;
            strobe_o <= gpdr_pkg::STROBE_IDLE;
        end else begin
            state <= next_state;
            word <= next_word;
            ready_o <= next_ready;
            pins_o <= next_pins;
            drive_o <= next_drive;
            strobe_o <= next_strobe;
        end
    end

endmodule

/* File: src/gpdr_host.sv */
`timescale 1ns/1ps

module gpdr_host (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic double_rate_mode_i,
    input wire logic qw_valid_i,
    input wire gpdr_pkg::gpdr_qword_t qw_i,
    output logic qw_ready_o,
    input wire logic sb_valid_i,
    input wire logic [2*gpdr_pkg::SB_W-1:0] sb_cmd_i,
    output logic sb_ready_o,
    output logic link_clk_o,
    output logic [gpdr_pkg::AD_W-1:0] addr_data_o,
    output logic [gpdr_pkg::BE_W-1:0] byte_en_n_o,
    output logic addr_data_oe_o,
    output logic data_strobe_o,
    output logic xfer_ready_n_o,
    output logic [gpdr_pkg::SB_W-1:0] sideband_address_port_o,
    output logic sideband_address_port_oe_o,
    output logic sideband_strobe_o,
    output logic double_rate_mode_o
);

    logic [1:0] phase;
    logic mode_dbl;
    logic next_mode_dbl;
    logic [2*gpdr_pkg::AD_LANE_W-1:0] ad_word;
    gpdr_pkg::gpdr_ad_pins_t ad_pins;
    logic ad_drive;
    logic sb_drive;
    logic next_ready_n;
    // Tracks the second period of a single-rate Qword
    logic ad_second;
    logic next_ad_second;
    gpdr_pkg::gpdr_ad_pins_t ad_lo_seen;
    gpdr_pkg::gpdr_ad_pins_t next_ad_lo_seen;

    // ************************************************************
    // Interface clock
    // ************************************************************
    // This end makes the shared clock; flow control runs on its phases
    gpdr_clkgen u_clkgen (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .phase_o(phase),
        .link_clk_o(link_clk_o)
    );

    // ************************************************************
    // Transfer mode
    // ************************************************************
    // One mode bit for every group; it only changes while all lanes
    // stand idle and outside the load phase, so no word is split
    always_comb begin
        next_mode_dbl = mode_dbl;
        if (!ad_drive && !sb_drive && (phase != gpdr_pkg::PH_LOAD)) begin
            next_mode_dbl = double_rate_mode_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_dbl <= gpdr_pkg::MODE_RST;
            double_rate_mode_o <= gpdr_pkg::MODE_RST;
        end else begin
            mode_dbl <= next_mode_dbl;
            double_rate_mode_o <= next_mode_dbl;
        end
    end

    // ************************************************************
    // Address/data and byte enable lane
    // ************************************************************
    // Byte enables travel inverted with their dword; no parity pins
    assign ad_word = {~qw_i.be[2*gpdr_pkg::BE_W-1:gpdr_pkg::BE_W],
                      qw_i.data[2*gpdr_pkg::AD_W-1:gpdr_pkg::AD_W],
                      ~qw_i.be[gpdr_pkg::BE_W-1:0],
                      qw_i.data[gpdr_pkg::AD_W-1:0]};

    gpdr_lane #(
        .W(gpdr_pkg::AD_LANE_W),
        .IDLE_VAL({gpdr_pkg::AD_LANE_W{1'b0}})
    ) u_ad_lane (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .phase_i(phase),
        .double_rate_i(mode_dbl),
        .valid_i(qw_valid_i),
        .word_i(ad_word),
        .ready_o(qw_ready_o),
        .pins_o(ad_pins),
        .drive_o(ad_drive),
        .strobe_o(data_strobe_o)
    );

    assign addr_data_o = ad_pins.addr_data;
    assign byte_en_n_o = ad_pins.byte_en_n;
    assign addr_data_oe_o = ad_drive;

    // ************************************************************
    // Sideband lane
    // ************************************************************
    gpdr_lane #(
        .W(gpdr_pkg::SB_W),
        .IDLE_VAL({gpdr_pkg::SB_W{1'b1}})
    ) u_sb_lane (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .phase_i(phase),
        .double_rate_i(mode_dbl),
        .valid_i(sb_valid_i),
        .word_i(sb_cmd_i),
        .ready_o(sb_ready_o),
        .pins_o(sideband_address_port_o),
        .drive_o(sb_drive),
        .strobe_o(sideband_strobe_o)
    );

    assign sideband_address_port_oe_o = sb_drive;

    // ************************************************************
    // Outer-loop ready
    // ************************************************************
    // Asserted for every clock period that carries data, so the far
    // receiver can count the periods of each Qword from it
    always_comb begin
        next_ready_n = xfer_ready_n_o;
        if (phase == gpdr_pkg::PH_LOAD) begin
            next_ready_n = !((qw_valid_i && qw_ready_o) || (ad_drive && !mode_dbl &&
                           (ad_pins == ad_lo_seen) && !ad_second));
        end
    end

    // Second-period tracking and the low half last taken
    always_comb begin
        next_ad_second = ad_second;
        next_ad_lo_seen = ad_lo_seen;
        if (phase == gpdr_pkg::PH_LOAD) begin
            next_ad_second = ad_drive && !mode_dbl && !ad_second &&
                             !(qw_valid_i && qw_ready_o && !xfer_ready_n_o);
            if (qw_valid_i && qw_ready_o) begin
                next_ad_second = 1'b0;
            end
        end
        if (qw_valid_i && qw_ready_o) begin
            next_ad_lo_seen = ad_word[gpdr_pkg::AD_LANE_W-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            xfer_ready_n_o <= 1'b1;
            ad_second <= 1'b0;
            ad_lo_seen <= '0;
        end else begin
            xfer_ready_n_o <= next_ready_n;
            ad_second <= next_ad_second;
            ad_lo_seen <= next_ad_lo_seen;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Last accepted words, read only by the checks below
    logic [2*gpdr_pkg::AD_LANE_W-1:0] chk_ad;
    logic [2*gpdr_pkg::SB_W-1:0] chk_sb;
    logic [2*gpdr_pkg::AD_LANE_W-1:0] next_chk_ad;
    logic [2*gpdr_pkg::SB_W-1:0] next_chk_sb;
    logic acc_ad;
    logic acc_sb;

    always_comb begin
        acc_ad = qw_valid_i && qw_ready_o;
        acc_sb = sb_valid_i && sb_ready_o;
        next_chk_ad = acc_ad ? ad_word : chk_ad;
        next_chk_sb = acc_sb ? sb_cmd_i : chk_sb;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chk_ad <= '0;
            chk_sb <= '0;
        end else begin
            chk_ad <= next_chk_ad;
            chk_sb <= next_chk_sb;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_link_clk_shape: assert property (
        $rose(link_clk_o) |-> link_clk_o[*2] ##1 !link_clk_o[*2] ##1 link_clk_o)
        else $error("interface clock is not a steady divide by four");

    a_one_rate_qword: assert property (
        acc_ad && !mode_dbl |=>
        (ad_pins == chk_ad[gpdr_pkg::AD_LANE_W-1:0])[*4] ##1
        (ad_pins == chk_ad[2*gpdr_pkg::AD_LANE_W-1:gpdr_pkg::AD_LANE_W])[*4])
        else $error("single-rate Qword does not span two clocks");

    a_two_rate_qword: assert property (
        acc_ad && mode_dbl |=>
        (ad_pins == chk_ad[gpdr_pkg::AD_LANE_W-1:0])[*2] ##1
        (ad_pins == chk_ad[2*gpdr_pkg::AD_LANE_W-1:gpdr_pkg::AD_LANE_W])[*2])
        else $error("double-rate Qword does not fit one clock");

    a_one_rate_cmd: assert property (
        acc_sb && !mode_dbl |=>
        (sideband_address_port_o == chk_sb[gpdr_pkg::SB_W-1:0])[*4] ##1
        (sideband_address_port_o == chk_sb[2*gpdr_pkg::SB_W-1:gpdr_pkg::SB_W])[*4])
        else $error("single-rate sideband command does not span two clocks");

    a_two_rate_cmd: assert property (
        acc_sb && mode_dbl |=> sideband_strobe_o ##1 !sideband_strobe_o ##2
        sideband_strobe_o && sideband_address_port_o == chk_sb[2*gpdr_pkg::SB_W-1:gpdr_pkg::SB_W])
        else $error("double-rate sideband command does not fit one clock");

    a_strobe_edges: assert property (
        $fell(data_strobe_o) |-> $stable(addr_data_o) ##1 !data_strobe_o ##1
        $rose(data_strobe_o) && $stable(addr_data_o))
        else $error("strobe edges not centred in their halves");

    a_fall_first_period: assert property (
        $fell(data_strobe_o) |-> link_clk_o && !xfer_ready_n_o && $past(link_clk_o))
        else $error("strobe fall outside first clock period");

    a_mode_group: assert property (
        $changed(mode_dbl) |-> !addr_data_oe_o && !sideband_address_port_oe_o)
        else $error("mode changed while a lane was busy");

    a_single_no_strobe: assert property (
        (!mode_dbl || !addr_data_oe_o) |-> data_strobe_o)
        else $error("data strobe toggles outside double-rate transfer");

    a_ready_on_clock: assert property (
        $fell(xfer_ready_n_o) |-> $rose(link_clk_o))
        else $error("ready not aligned to the interface clock");

    c_two_rate_burst: cover property (acc_ad && mode_dbl ##4 acc_ad);
    c_one_rate_qword: cover property (acc_ad && !mode_dbl);
    c_two_rate_cmd: cover property (acc_sb && mode_dbl);
    c_mode_switch: cover property ($changed(mode_dbl));

endmodule

/* File: tb/gpdr_device_model.sv */
`timescale 1ns/1ps

// ************************************************************
// Receiving end of the port, behavioural
// ************************************************************
module gpdr_device_model (
    input wire logic link_clk_i,
    input wire logic arst_n_i,
    input wire logic double_rate_mode_i,
    input wire logic [gpdr_pkg::AD_W-1:0] addr_data_i,
    input wire logic [gpdr_pkg::BE_W-1:0] byte_en_n_i,
    input wire logic data_strobe_i,
    input wire logic xfer_ready_n_i,
    input wire logic [gpdr_pkg::SB_W-1:0] sideband_address_port_i,
    input wire logic sideband_address_port_oe_i,
    input wire logic sideband_strobe_i,
    output gpdr_pkg::gpdr_qword_t qw_o,
    output logic [15:0] qw_cnt_o,
    output logic [2*gpdr_pkg::SB_W-1:0] sb_o,
    output logic [15:0] sb_cnt_o
);
    gpdr_pkg::gpdr_ad_pins_t lo_half;
    gpdr_pkg::gpdr_qword_t stage [2];
    logic [gpdr_pkg::SB_W-1:0] sb_lo;
    logic wr_sel, rd_sel, t1_mark, t2_live, ad_hi, sb_hi;

    // Pointers start clean once the pins have settled
    always @(posedge arst_n_i) begin
        {wr_sel, rd_sel, t1_mark, t2_live, ad_hi, sb_hi} = '0;
        qw_cnt_o = '0;
        sb_cnt_o = '0;
    end

    // Inner loop: capture straight off the strobe, both edges
    always @(negedge data_strobe_i) begin
        if (arst_n_i) lo_half = {byte_en_n_i, addr_data_i};
    end
    // Rise may land in the next period; two stages keep it safe
    always @(posedge data_strobe_i) begin
        if (arst_n_i) begin
            stage[wr_sel] = {~byte_en_n_i, ~lo_half.byte_en_n, addr_data_i,
                lo_half.addr_data};
            wr_sel = ~wr_sel;
        end
    end
    // Sideband has no ready event, so hand over at the rise
    always @(negedge sideband_strobe_i) begin
        if (arst_n_i) sb_lo = sideband_address_port_i;
    end
    always @(posedge sideband_strobe_i) begin
        if (arst_n_i) begin
            sb_o = {sideband_address_port_i, sb_lo};
            sb_cnt_o++;
        end
    end

    // Outer loop sampled mid-period, where the pins are settled
    always @(negedge link_clk_i) begin
        if (arst_n_i && !xfer_ready_n_i && double_rate_mode_i) t1_mark = 1'b1;
        if (arst_n_i && !xfer_ready_n_i && !double_rate_mode_i) begin
            if (ad_hi) begin
                qw_o = {~byte_en_n_i, ~lo_half.byte_en_n, addr_data_i, lo_half.addr_data};
                qw_cnt_o++;
            end
            lo_half = {byte_en_n_i, addr_data_i};
            ad_hi = ~ad_hi;
        end
        if (arst_n_i && sideband_address_port_oe_i && !double_rate_mode_i) begin
            if (sb_hi) begin
                sb_o = {sideband_address_port_i, sb_lo};
                sb_cnt_o++;
            end
            sb_lo = sideband_address_port_i;
            sb_hi = ~sb_hi;
        end
    end

    // Handover no earlier than the end of the second period
    always @(posedge link_clk_i) begin
        if (arst_n_i && t2_live) begin
            qw_o = stage[rd_sel];
            rd_sel = ~rd_sel;
            qw_cnt_o++;
        end
        t2_live = t1_mark;
        t1_mark = 1'b0;
    end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps

// ************************************************************
// Host end against a behavioural receiver
// ************************************************************
module testbench;
    localparam int TIMEOUT_CYCLES = 20000;
    logic core_clk_i, arst_n_i, double_rate_mode_i, qw_valid_i, sb_valid_i;
    gpdr_pkg::gpdr_qword_t qw_i, got_qw;
    logic [2*gpdr_pkg::SB_W-1:0] sb_cmd_i, got_sb;
    logic qw_ready_o, sb_ready_o, link_clk_o, addr_data_oe_o, data_strobe_o;
    logic [gpdr_pkg::AD_W-1:0] addr_data_o;
    logic [gpdr_pkg::BE_W-1:0] byte_en_n_o;
    logic xfer_ready_n_o, sideband_address_port_oe_o, sideband_strobe_o, double_rate_mode_o;
    logic [gpdr_pkg::SB_W-1:0] sideband_address_port_o;
    logic [15:0] got_qw_cnt, got_sb_cnt;
    logic prev_link, prev_dstb, prev_sstb, prev_mode, prev_oe, link_seen;
    logic [31:0] link_run, n_ad_cyc, n_sb_cyc;
    int n_errors = 0;
    int n_compared = 0;
    int n_cyc = 0;
    gpdr_pkg::gpdr_qword_t exp_qw[$];
    logic [15:0] exp_sb[$];

    gpdr_host gpdr_host_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .double_rate_mode_i(double_rate_mode_i), .qw_valid_i(qw_valid_i), .qw_i(qw_i),
        .qw_ready_o(qw_ready_o), .sb_valid_i(sb_valid_i), .sb_cmd_i(sb_cmd_i),
        .sb_ready_o(sb_ready_o), .link_clk_o(link_clk_o), .addr_data_o(addr_data_o),
        .byte_en_n_o(byte_en_n_o), .addr_data_oe_o(addr_data_oe_o),
        .data_strobe_o(data_strobe_o), .xfer_ready_n_o(xfer_ready_n_o),
        .sideband_address_port_o(sideband_address_port_o),
        .sideband_address_port_oe_o(sideband_address_port_oe_o),
        .sideband_strobe_o(sideband_strobe_o), .double_rate_mode_o(double_rate_mode_o));

    gpdr_device_model gpdr_device_model_inst (.link_clk_i(link_clk_o), .arst_n_i(arst_n_i),
        .double_rate_mode_i(double_rate_mode_o), .addr_data_i(addr_data_o),
        .byte_en_n_i(byte_en_n_o), .data_strobe_i(data_strobe_o),
        .xfer_ready_n_i(xfer_ready_n_o), .sideband_address_port_i(sideband_address_port_o),
        .sideband_address_port_oe_i(sideband_address_port_oe_o),
        .sideband_strobe_i(sideband_strobe_o), .qw_o(got_qw), .qw_cnt_o(got_qw_cnt),
        .sb_o(got_sb), .sb_cnt_o(got_sb_cnt));

    // ************************************************************
    // Comparison and closing
    // ************************************************************
    task automatic chk_qw(input gpdr_pkg::gpdr_qword_t g, input gpdr_pkg::gpdr_qword_t e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_num(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Core cycles that one Qword or command keeps its lane busy
    function automatic logic [31:0] xfer_cycles(input logic dbl);
        return dbl ? 32'(gpdr_pkg::LINK_DIV) : 32'(2 * gpdr_pkg::LINK_DIV);
    endfunction

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // ************************************************************
    // Monitors on the pins, sampled mid-cycle where they are settled
    // ************************************************************
    always @(negedge core_clk_i) begin
        n_cyc++;
        if (arst_n_i) begin
            if (!xfer_ready_n_o) n_ad_cyc++;
            if (sideband_address_port_oe_o) n_sb_cyc++;
            if (link_clk_o && !prev_link) begin
                if (link_seen) chk_num(link_run, 32'(gpdr_pkg::LINK_DIV));
                link_run = 1;
                link_seen = 1'b1;
            end else begin
                link_run++;
            end
            if (prev_dstb && !data_strobe_o) chk_num({link_clk_o, double_rate_mode_o,
                xfer_ready_n_o}, 32'h6);
            if (prev_sstb && !sideband_strobe_o) chk_num({link_clk_o, double_rate_mode_o,
                sideband_address_port_oe_o}, 32'h7);
            if (double_rate_mode_o !== prev_mode) chk_num({prev_oe, addr_data_oe_o,
                sideband_address_port_oe_o}, 32'h0);
        end
        {prev_link, prev_dstb, prev_sstb, prev_mode} = {link_clk_o, data_strobe_o,
            sideband_strobe_o, double_rate_mode_o};
        prev_oe = addr_data_oe_o | sideband_address_port_oe_o;
        if (n_cyc >= TIMEOUT_CYCLES) begin
            n_errors++;
            give_verdict();
        end
    end

    // Receiver deliveries against what was accepted, in order
    always @(got_qw_cnt) begin
        if (got_qw_cnt != 0 && exp_qw.size() == 0) chk_num(32'h0, 32'h1);
        else if (got_qw_cnt != 0) chk_qw(got_qw, exp_qw.pop_front());
    end
    always @(got_sb_cnt) begin
        if (got_sb_cnt != 0 && exp_sb.size() == 0) chk_num(32'h0, 32'h1);
        else if (got_sb_cnt != 0) chk_num(32'(got_sb), 32'(exp_sb.pop_front()));
    end

    // ************************************************************
    // Drivers: hold the offer until ready is seen at an edge
    // ************************************************************
    task automatic send_qw(input int i);
        if ($urandom_range(3) == 0) begin
            qw_valid_i = 1'b0;
            repeat ($urandom_range(6, 1)) @(posedge core_clk_i);
            #1;
        end
        qw_i.data = (i == 0) ? 64'hffff_ffff_0000_0000 : {$urandom, $urandom};
        qw_i.be = (i == 0) ? 8'h0f : 8'($urandom);
        qw_valid_i = 1'b1;
        do @(posedge core_clk_i); while (qw_ready_o !== 1'b1);
        exp_qw.push_back(qw_i);
        #1;
    endtask
    task automatic send_sb(input int i);
        sb_cmd_i = (i == 0) ? 16'h00ff : 16'($urandom);
        sb_valid_i = 1'b1;
        do @(posedge core_clk_i); while (sb_ready_o !== 1'b1);
        exp_sb.push_back(sb_cmd_i);
        #1;
    endtask

    // One batch in one mode; a flip in mid-batch must wait for idle
    task automatic run_batch(input logic dbl, input int n, input bit flip);
        logic [31:0] a0, s0;
        double_rate_mode_i = dbl;
        while (double_rate_mode_o !== dbl) @(posedge core_clk_i);
        #1;
        chk_num(32'(double_rate_mode_o), 32'(dbl));
        a0 = n_ad_cyc;
        s0 = n_sb_cyc;
        fork
            begin
                for (int i = 0; i < n; i++) send_qw(i);
                qw_valid_i = 1'b0;
            end
            begin
                for (int i = 0; i < n; i++) send_sb(i);
                sb_valid_i = 1'b0;
            end
            if (flip) begin
                repeat (6) @(posedge core_clk_i);
                #1 double_rate_mode_i = ~dbl;
            end
        join
        while (exp_qw.size() + exp_sb.size() != 0) @(posedge core_clk_i);
        repeat (4) @(posedge core_clk_i);
        #1;
        if (!flip) chk_num(n_ad_cyc - a0, n * xfer_cycles(dbl));
        if (!flip) chk_num(n_sb_cyc - s0, n * xfer_cycles(dbl));
    endtask

    initial begin
        {arst_n_i, double_rate_mode_i, qw_valid_i, sb_valid_i} = '0;
        qw_i = '0;
        sb_cmd_i = '0;
        {n_ad_cyc, n_sb_cyc, link_run, link_seen} = '0;
        void'($urandom(32'h6000));
        repeat (4) @(posedge core_clk_i);
        chk_num({data_strobe_o, sideband_strobe_o, addr_data_oe_o,
            sideband_address_port_oe_o, xfer_ready_n_o, double_rate_mode_o}, 32'h32);
        chk_num(32'(sideband_address_port_o), 32'hff);
        #1 arst_n_i = 1'b1;
        run_batch(1'b1, 6, 1'b0);
        run_batch(1'b0, 4, 1'b0);
        run_batch(1'b1, 3, 1'b1);
        run_batch(1'b0, 3, 1'b1);
        for (int b = 0; b < 4; b++) run_batch(1'($urandom), $urandom_range(5, 1), 1'b0);
        give_verdict();
    end
endmodule
